// [bench/pgw_load.sv]
// Load model that times the power-good lead before switching stops.
`timescale 1ns/1ps
`default_nettype none
module pgw_load (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Watched lines
   input wire logic pg_out,
   input wire logic resonant_switch_en,
   output int lead
);
   logic pg_q;
   logic run;
   int cnt;
   // A warning only counts while the converter is still switching.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pg_q <= 1'b0;
         run <= 1'b0;
         cnt <= 0;
         lead <= -1;
      end else begin
         pg_q <= pg_out;
         if (pg_q && !pg_out) begin
            run <= 1'b1;
            cnt <= 0;
         end else if (run && !resonant_switch_en) begin
            run <= 1'b0;
            lead <= cnt;
         end else if (run) begin
            cnt <= cnt + 1;
         end
      end
   end
endmodule : pgw_load
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the power-good prewarning block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pgw_pkg::*;
   localparam logic [31:0] VW = 32'hAC43_2003;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [5:0] cz = 6'h0;
   logic [11:0] boost_sense_mv = 12'h07D0;
   logic out_in_regulation = 1'b0;
   logic [1:0] gate_res_sel = 2'h2;
   wire logic hreadyout, hresp, pg_out, resonant_switch_en, irq;
   wire logic [31:0] hrdata;
   wire logic [5:0] pg_level;
   wire logic [11:0] act_overpower1_ms;
   wire logic [9:0] act_overcur_cycles;
   wire logic [4:0] act_restart, act_resp_latched;
   int errors = 0, compares = 0, cyc = 0, lead, n;
   logic [31:0] r;
   initial begin
      forever #2.5 hclk = ~hclk;
   end
   pgw_core #(.MS_CYCLES(200)) u_pgw_core (.hclk, .hresetn,
      .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .otp_int(cz[0]), .otp_ext(cz[1]), .overpower1_over(cz[2]),
      .overpower2_over(cz[3]), .mains_below(cz[4]), .boost_ovp(cz[5]),
      .boost_sense_mv, .out_in_regulation, .gate_res_sel, .pg_out,
      .pg_level, .resonant_switch_en, .act_overpower1_ms,
      .act_overcur_cycles, .act_restart, .act_resp_latched, .irq);
   pgw_load u_pgw_load (.hclk, .hresetn, .pg_out, .resonant_switch_en,
      .lead);
   task close_out;
      $display("errors=%0d compares=%0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : close_out
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task rng(input int v, input int lo, input int hi);
      chk(32'(v >= lo && v <= hi), 32'h1);
   endtask : rng
   // The slave may stretch either phase, so both waits poll hready.
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
      chk({31'h0, hresp}, 32'h0);
   endtask : rdchk
   task wt(input bit s, input logic v, input int lim, output int c);
      c = 0;
      while (((s ? resonant_switch_en : pg_out) !== v) && c < lim) begin
         @(posedge hclk);
         c++;
      end
      rng(c, 0, lim - 1);
   endtask : wt
   task cause(input int k, input logic on);
      if (k < 6) cz[k] <= on;
      else if (k == 6) boost_sense_mv <= on ? 12'h03FC : 12'h07D0;
      else boost_sense_mv <= on ? 12'h0384 : 12'h07D0;
   endtask : cause
   task t_regs;
      rdchk(ADDR_CTRL, {20'h0, CTRL_RESET});
      rdchk(ADDR_VERSION0, VERSION_RESET);
      rdchk(ADDR_IRQ_MASK, 32'h0);
      rdchk(8'h3C, 32'h0);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(r & 32'h7F, 32'h42);
   endtask : t_regs
   task t_ready;
      bus(1'b1, ADDR_TIME, 32'h6402);
      bus(1'b1, ADDR_OVERPOWER2, 32'h5);
      bus(1'b1, 8'h24, 32'h0);
      bus(1'b1, 8'h28, VW);
      out_in_regulation <= 1'b1;
      wt(0, 1'b1, 2000, n);
      rng(n, 399, 410);
      repeat (220) @(posedge hclk);
      chk({26'h0, pg_level}, 32'h30);
   endtask : t_ready
   task t_ver;
      chk({20'h0, act_overpower1_ms}, {20'h0, VW[11:0]});
      chk({22'h0, act_overcur_cycles}, {22'h0, VW[21:12]});
      chk({27'h0, act_resp_latched}, {27'h0, VW[26:22]});
      chk({27'h0, act_restart}, {27'h0, VW[31:27]});
   endtask : t_ver
   task t_warn;
      bus(1'b1, ADDR_IRQ_MASK, 32'h1);
      for (int k = 0; k < 7; k++) begin
         cause(k, 1'b1);
         wt(1, 1'b0, 8000, n);
         @(posedge hclk);
         rng(lead, 398, 410);
         chk({26'h0, pg_level}, 32'h0);
         cause(k, 1'b0);
         wt(0, 1'b1, 3000, n);
      end
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(r & 32'h1, 32'h1);
      bus(1'b1, ADDR_IRQ_STAT, 32'h7);
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h0);
   endtask : t_warn
   task t_hard;
      bus(1'b1, ADDR_CTRL, 32'h20);
      for (int k = 0; k < 8; k++) begin
         if (k == 6) continue;
         cause(k, 1'b1);
         wt(1, 1'b0, 8000, n);
         if (k == 7) rng(n, 1, 3);
         // The load posts its lead one edge after it sees the stop.
         repeat (2) @(posedge hclk);
         rng(lead, 0, 0);
         cause(k, 1'b0);
         wt(0, 1'b1, 3000, n);
      end
      bus(1'b1, ADDR_CTRL, 32'h10);
      cz[5] <= 1'b1;
      repeat (1500) @(posedge hclk);
      chk({31'h0, resonant_switch_en}, 32'h1);
      cz[5] <= 1'b0;
   endtask : t_hard
   // Longest pg time and transition, top threshold step, threshold cause.
   task t_modes;
      bus(1'b1, ADDR_CTRL, 32'h3C8);
      bus(1'b1, ADDR_LEVEL, 32'h3E8F);
      boost_sense_mv <= 12'h0780;
      repeat (8) @(posedge hclk);
      chk({31'h0, pg_out}, 32'h1);
      boost_sense_mv <= 12'h0758;
      wt(1, 1'b0, 8000, n);
      repeat (2) @(posedge hclk);
      rng(lead, 1598, 1610);
      boost_sense_mv <= 12'h07D0;
      wt(0, 1'b1, 3000, n);
      repeat (400) @(posedge hclk);
      rng(pg_level, 22, 27);
   endtask : t_modes
   // The strap is read once: a later change waits for the next reset.
   task t_reset;
      gate_res_sel <= 2'h1;
      repeat (3) @(posedge hclk);
      chk({20'h0, act_overpower1_ms}, {20'h0, VW[11:0]});
      hresetn <= 1'b0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk(ADDR_CTRL, {20'h0, CTRL_RESET});
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(r & 32'h60, 32'h20);
   endtask : t_reset
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         errors++;
         close_out;
      end
   end
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs;
      t_ready;
      t_ver;
      t_warn;
      t_modes;
      t_hard;
      t_reset;
      close_out;
   end
endmodule : testbench
`default_nettype wire

// [core/pgw_core.sv]
// Power-good prewarning sequencer with AHB-Lite registers.
// What this block does
// - warn, keep switching pg time, then stop
// - temperature prewarn enable, internal or external
// - overpower level one or two after duration
// - prewarn before mains brownout switch-off
// - stop switching below boost-sense brownout level
// - boost-sense below selectable threshold drops pg
// - boost overvoltage stops only if selected
// - prewarn before maximum input voltage switch-off
// - pg rises after programmable ready delay
// - ramp pg over 1 to 4 ms
// - four versions, chosen by gate resistor
// - only per-version fields differ between versions
// - five response types set per version
// - both overpower levels share one response
// - mains brownout after selectable qualification time
`timescale 1ns/1ps
`default_nettype none
module pgw_core #(
   parameter int MS_CYCLES = pgw_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Detector inputs
   input wire logic otp_int,
   input wire logic otp_ext,
   input wire logic overpower1_over,
   input wire logic overpower2_over,
   input wire logic mains_below,
   input wire logic boost_ovp,
   input wire logic [11:0] boost_sense_mv,
   input wire logic out_in_regulation,
   input wire logic [1:0] gate_res_sel,
   // Power good and converter control
   output logic pg_out,
   output logic [5:0] pg_level,
   output logic resonant_switch_en,
   // Active parameter version
   output logic [11:0] act_overpower1_ms,
   output logic [9:0] act_overcur_cycles,
   output logic [4:0] act_restart,
   output logic [4:0] act_resp_latched,
   // Interrupt
   output logic irq
);
   import pgw_pkg::*;

   initial begin
      if (MS_CYCLES < 2 * RAMP_STEPS) begin
         $error("pgw_core: MS_CYCLES too small for the ramp");
      end
   end

   logic [11:0] ctrl;
   logic [3:0] bs_thr_sel;
   logic [11:0] bo_mv;
   logic [9:0] ready_ms;
   logic [11:0] mains_ms;
   logic [11:0] overpower2_ms;
   logic [31:0] version [NUM_VERSIONS];
   logic [2:0] irq_stat;
   logic [2:0] irq_mask;
   logic [1:0] ver;
   logic ver_taken;
   logic wr_pend;
   logic [7:0] wr_addr;
   pgw_state_e state;
   pgw_state_e next_state;

   // Bus access: zero wait states, always OKAY.
   logic acc;
   assign acc = hsel && hready && htrans[1];

   function automatic logic [31:0] read_reg(input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == ADDR_CTRL) r = {20'h0_0000, ctrl};
      else if (a == ADDR_LEVEL) r = {16'h0000, bo_mv, bs_thr_sel};
      else if (a == ADDR_TIME) r = {10'h000, mains_ms, ready_ms};
      else if (a == ADDR_OVERPOWER2) r = {20'h0_0000, overpower2_ms};
      else if (a == ADDR_STATUS)
         r = {19'h0_0000, pg_level, ver, state, resonant_switch_en, pg_out};
      else if (a == ADDR_IRQ_STAT) r = {29'h0000_0000, irq_stat};
      else if (a == ADDR_IRQ_MASK) r = {29'h0000_0000, irq_mask};
      else if (a[7:4] == ADDR_VERSION0[7:4] && a[1:0] == 2'b00)
         r = version[a[3:2]];
      return r;
   endfunction : read_reg

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= acc && hwrite;
         if (acc) begin
            wr_addr <= haddr[7:0];
         end
         if (acc && !hwrite) begin
            hrdata <= read_reg(haddr[7:0]);
         end
      end
   end

   // Out-of-range times are clamped so the timers never see them.
   function automatic logic [11:0] clamp_mains(input logic [11:0] v);
      return (v < MAINS_MIN_MS) ? MAINS_MIN_MS :
             (v > MAINS_MAX_MS) ? MAINS_MAX_MS : v;
   endfunction : clamp_mains

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RESET;
         bs_thr_sel <= BS_THR_SEL_RESET;
         bo_mv <= BO_MV_RESET;
         ready_ms <= READY_MS_RESET;
         mains_ms <= MAINS_MS_RESET;
         overpower2_ms <= OVERPOWER2_MS_RESET;
      end else if (wr_pend) begin
         if (wr_addr == ADDR_CTRL) ctrl <= hwdata[11:0];
         if (wr_addr == ADDR_LEVEL) begin
            bs_thr_sel <= hwdata[3:0];
            bo_mv <= hwdata[LEVEL_BO_LSB +: 12];
         end
         if (wr_addr == ADDR_TIME) begin
            ready_ms <= (hwdata[9:0] > READY_MAX_MS) ? READY_MAX_MS :
                        hwdata[9:0];
            mains_ms <= clamp_mains(hwdata[TIME_MAINS_LSB +: 12]);
         end
         if (wr_addr == ADDR_OVERPOWER2) overpower2_ms <= hwdata[11:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < NUM_VERSIONS; i++) begin
            version[i] <= VERSION_RESET;
         end
      end else if (wr_pend && wr_addr[7:4] == ADDR_VERSION0[7:4]
                   && wr_addr[1:0] == 2'b00) begin
         version[wr_addr[3:2]] <= hwdata;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ver <= 2'b00;
         ver_taken <= 1'b0;
      end else if (!ver_taken) begin
         ver <= gate_res_sel;
         ver_taken <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_overpower1_ms <= 12'h000;
         act_overcur_cycles <= 10'h000;
         act_resp_latched <= 5'h00;
         act_restart <= 5'h00;
      end else begin
         act_overpower1_ms <= version[ver][11:0];
         act_overcur_cycles <= version[ver][VER_OVERCUR_LSB +: 10];
         act_resp_latched <= version[ver][VER_RESP_LSB +: 5];
         act_restart <= version[ver][VER_RESTART_LSB +: 5];
      end
   end

   // Enables and selections.
   logic en_otp, en_overpower, en_mains, en_bs, en_ovp, ovp_disable;
   logic [1:0] pg_time_sel, trans_sel, ovp_dly_sel;
   logic [11:0] pg_time_ms, ovp_dly_ms, bs_thr_mv, phase_limit;
   assign en_otp = ctrl[0];
   assign en_overpower = ctrl[1];
   assign en_mains = ctrl[2];
   assign en_bs = ctrl[3];
   assign en_ovp = ctrl[4];
   assign ovp_disable = ctrl[5];
   assign pg_time_sel = ctrl[CTRL_PG_TIME_LSB +: 2];
   assign trans_sel = ctrl[CTRL_TRANS_LSB +: 2];
   assign ovp_dly_sel = ctrl[CTRL_OVP_DLY_LSB +: 2];
   assign pg_time_ms = {9'h000, pg_time_sel, 1'b0} + 12'h002;
   assign ovp_dly_ms = (ovp_dly_sel == 2'b00) ? OVP_DLY0_MS :
                       (ovp_dly_sel == 2'b01) ? OVP_DLY1_MS : OVP_DLY2_MS;
   assign bs_thr_mv = (bs_thr_sel == 4'h0) ? BS_THR0_MV :
                      BS_BASE_MV + BS_STEP_MV * {8'h00, bs_thr_sel};

   // The overpower, mains and overvoltage timers share one free-running millisecond tick.
   logic ms_tick, phase_tick, ramp_tick, phase_run;
   logic overpower1_done, overpower2_done, mains_done, ovp_done, phase_done;
   pgw_tick #(.DIV(MS_CYCLES)) u_ms_tick (
      .hclk(hclk), .hresetn(hresetn), .clr(1'b0), .tick(ms_tick));
   // The phase tick restarts with its timer so no partial ms is lost.
   pgw_tick #(.DIV(MS_CYCLES)) u_phase_tick (
      .hclk(hclk), .hresetn(hresetn), .clr(!phase_run),
      .tick(phase_tick));
   pgw_tick #(.DIV(MS_CYCLES / RAMP_STEPS)) u_ramp_tick (
      .hclk(hclk), .hresetn(hresetn), .clr(1'b0), .tick(ramp_tick));
   pgw_timer #(.W(12)) u_overpower1 (
      .hclk(hclk), .hresetn(hresetn), .run(overpower1_over),
      .tick(ms_tick), .limit(act_overpower1_ms), .done(overpower1_done));
   pgw_timer #(.W(12)) u_overpower2 (
      .hclk(hclk), .hresetn(hresetn), .run(overpower2_over),
      .tick(ms_tick), .limit(overpower2_ms), .done(overpower2_done));
   pgw_timer #(.W(12)) u_mains (
      .hclk(hclk), .hresetn(hresetn), .run(mains_below),
      .tick(ms_tick), .limit(mains_ms), .done(mains_done));
   pgw_timer #(.W(12)) u_ovp (
      .hclk(hclk), .hresetn(hresetn), .run(boost_ovp),
      .tick(ms_tick), .limit(ovp_dly_ms), .done(ovp_done));
   pgw_timer #(.W(12)) u_phase (
      .hclk(hclk), .hresetn(hresetn), .run(phase_run),
      .tick(phase_tick), .limit(phase_limit), .done(phase_done));

   // Switch-off causes.
   logic c_otp, c_overpower, c_bsbo, c_ovp, c_bs_low;
   logic warn_trig, hard_stop, any_cause;
   assign c_otp = otp_int || otp_ext;
   assign c_overpower = overpower1_done || overpower2_done;
   assign c_bsbo = boost_sense_mv < bo_mv;
   assign c_ovp = ovp_done && ovp_disable;
   assign c_bs_low = boost_sense_mv < bs_thr_mv;
   assign warn_trig = (en_otp && c_otp) || (en_overpower && c_overpower)
                      || (en_mains && mains_done) || (en_bs && c_bs_low)
                      || (en_ovp && c_ovp);
   assign hard_stop = (!en_otp && c_otp) || (!en_overpower && c_overpower)
                      || (!en_mains && mains_done) || c_bsbo
                      || (!en_ovp && c_ovp);
   assign any_cause = c_otp || c_overpower || mains_done || c_bsbo
                      || c_ovp || (en_bs && c_bs_low);
   assign phase_run = (state == ST_READY || state == ST_WARN)
                      && next_state == state;
   assign phase_limit = (state == ST_READY) ? {2'b00, ready_ms} : pg_time_ms;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_OFF: begin
            if (hard_stop) next_state = ST_STOP;
            else if (warn_trig) next_state = ST_WARN;
            else if (out_in_regulation) next_state = ST_READY;
         end
         ST_READY: begin
            if (hard_stop) next_state = ST_STOP;
            else if (warn_trig) next_state = ST_WARN;
            else if (!out_in_regulation) next_state = ST_OFF;
            else if (phase_done) next_state = ST_GOOD;
         end
         ST_GOOD: begin
            if (hard_stop) next_state = ST_STOP;
            else if (warn_trig) next_state = ST_WARN;
            else if (!out_in_regulation) next_state = ST_OFF;
         end
         ST_WARN: begin
            if (hard_stop || phase_done) next_state = ST_STOP;
         end
         ST_STOP: begin
            if (!any_cause) next_state = ST_OFF;
         end
         default: next_state = ST_STOP;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_OFF;
         pg_out <= 1'b0;
         resonant_switch_en <= 1'b0;
      end else begin
         state <= next_state;
         pg_out <= (next_state == ST_GOOD);
         resonant_switch_en <= (next_state != ST_STOP);
      end
   end

   logic [1:0] ramp_sub;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ramp_sub <= 2'b00;
         pg_level <= 6'h00;
      end else if (ramp_tick) begin
         if (ramp_sub >= trans_sel) begin
            ramp_sub <= 2'b00;
            if (pg_out && pg_level < 6'(RAMP_STEPS)) begin
               pg_level <= pg_level + 1'b1;
            end else if (!pg_out && pg_level != 6'h00) begin
               pg_level <= pg_level - 1'b1;
            end
         end else begin
            ramp_sub <= ramp_sub + 1'b1;
         end
      end
   end

   // Sticky events: warn, stop, good; a new event beats its clear.
   logic [2:0] ev, next_irq_stat;
   always_comb begin
      ev[0] = (next_state == ST_WARN) && (state != ST_WARN);
      ev[1] = (next_state == ST_STOP) && (state != ST_STOP);
      ev[2] = (next_state == ST_GOOD) && (state != ST_GOOD);
      next_irq_stat = irq_stat;
      if (wr_pend && wr_addr == ADDR_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~hwdata[2:0];
      end
      next_irq_stat = next_irq_stat | ev;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat <= 3'h0;
         irq_mask <= 3'h0;
         irq <= 1'b0;
      end else begin
         irq_stat <= next_irq_stat;
         if (wr_pend && wr_addr == ADDR_IRQ_MASK) irq_mask <= hwdata[2:0];
         irq <= |(next_irq_stat & ((wr_pend && wr_addr == ADDR_IRQ_MASK)
                ? hwdata[2:0] : irq_mask));
      end
   end

   // Cycle counters used only by the checks below.
   logic [31:0] warn_cyc, ready_cyc;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         warn_cyc <= 32'h0000_0000;
         ready_cyc <= 32'h0000_0000;
      end else begin
         warn_cyc <= (state == ST_WARN) ? warn_cyc + 1 : 32'h0000_0000;
         ready_cyc <= (state == ST_READY) ? ready_cyc + 1 : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_warn_pg_low: assert property (
      state == ST_WARN |-> !pg_out && resonant_switch_en)
      else $error("pg high or switching stopped during warning");
   a_warn_lead_time: assert property (
      state == ST_WARN && next_state == ST_STOP && !hard_stop
      |-> warn_cyc >= 32'(pg_time_ms) * 32'(MS_CYCLES))
      else $error("warning ended before the pg time");
   a_otp_warn: assert property (
      state == ST_GOOD && en_otp && c_otp && !hard_stop
      |=> state == ST_WARN ##1 !pg_out)
      else $error("temperature prewarning not given");
   a_overpower_warn: assert property (
      state == ST_GOOD && en_overpower && c_overpower && !hard_stop
      |=> state == ST_WARN)
      else $error("overpower prewarning not given");
   a_mains_warn: assert property (
      state == ST_GOOD && en_mains && mains_done && !hard_stop
      |=> state == ST_WARN && resonant_switch_en)
      else $error("mains prewarning not given");
   a_bsbo_stop: assert property (
      c_bsbo |=> !resonant_switch_en && !pg_out)
      else $error("switching continued below brownout level");
   a_bs_thr: assert property (
      state == ST_GOOD && en_bs && c_bs_low |=> !pg_out)
      else $error("pg stayed high below boost-sense threshold");
   a_ovp_keep: assert property (
      state == ST_GOOD && ovp_done && !ovp_disable && !hard_stop
      && !warn_trig && out_in_regulation |=> resonant_switch_en)
      else $error("overvoltage stopped switching while not selected");
   a_ready_delay: assert property (
      state == ST_READY && next_state == ST_GOOD
      |-> ready_cyc >= 32'(ready_ms) * 32'(MS_CYCLES))
      else $error("pg rose before the ready delay");
   a_ramp_step: assert property (
      $changed(pg_level) |-> $past(ramp_tick) && pg_level <= 6'(RAMP_STEPS))
      else $error("pg ramp stepped off its tick or past its top");
   a_ver_hold: assert property (
      ver_taken |=> $stable(ver) && ver_taken)
      else $error("parameter version changed after capture");
   a_hard_stop: assert property (
      hard_stop && resonant_switch_en |=> !resonant_switch_en && !pg_out)
      else $error("unwarned cause did not stop at once");

   c_warn_then_stop: cover property (
      state == ST_WARN ##1 state == ST_STOP);
   c_ready_to_good: cover property (
      state == ST_READY ##1 state == ST_GOOD);
   c_stop_restart: cover property (state == ST_STOP ##1 state == ST_OFF);
   c_irq_raised: cover property ($rose(irq));
endmodule : pgw_core
`default_nettype wire

// [core/pgw_pkg.sv]
// Shared constants for the power-good prewarning block.
package pgw_pkg;
   // Register byte offsets.
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LEVEL = 8'h04;
   localparam logic [7:0] ADDR_TIME = 8'h08;
   localparam logic [7:0] ADDR_OVERPOWER2 = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] ADDR_VERSION0 = 8'h20;
   localparam int NUM_VERSIONS = 4;
   // Register field positions.
   localparam int CTRL_PG_TIME_LSB = 6;
   localparam int CTRL_TRANS_LSB = 8;
   localparam int CTRL_OVP_DLY_LSB = 10;
   localparam int LEVEL_BO_LSB = 4;
   localparam int TIME_MAINS_LSB = 10;
   localparam int VER_OVERCUR_LSB = 12;
   localparam int VER_RESP_LSB = 22;
   localparam int VER_RESTART_LSB = 27;
   // Values after reset.
   localparam logic [11:0] CTRL_RESET = 12'h03F;
   localparam logic [3:0] BS_THR_SEL_RESET = 4'h0;
   localparam logic [11:0] BO_MV_RESET = 12'h3E8;
   localparam logic [9:0] READY_MS_RESET = 10'h064;
   localparam logic [11:0] MAINS_MS_RESET = 12'h032;
   localparam logic [11:0] OVERPOWER2_MS_RESET = 12'h064;
   localparam logic [31:0] VERSION_RESET = 32'h0_3200_3E8;
   // Boost-sense prewarning threshold in millivolts.
   localparam logic [11:0] BS_THR0_MV = 12'h44C;
   localparam logic [11:0] BS_BASE_MV = 12'h47E;
   localparam logic [11:0] BS_STEP_MV = 12'h032;
   // Allowed ranges in milliseconds.
   localparam logic [11:0] MAINS_MIN_MS = 12'h019;
   localparam logic [11:0] MAINS_MAX_MS = 12'h4B0;
   localparam logic [9:0] READY_MAX_MS = 10'h3E8;
   localparam logic [11:0] OVP_DLY0_MS = 12'h005;
   localparam logic [11:0] OVP_DLY1_MS = 12'h032;
   localparam logic [11:0] OVP_DLY2_MS = 12'h1F4;
   // Timing: clock period and one millisecond, in picoseconds.
   localparam int CLK_PERIOD_PS = 5000;
   localparam int MS_PS = 1000000000;
   localparam int MS_CYCLES = MS_PS / CLK_PERIOD_PS;
   localparam int RAMP_STEPS = 48;
   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_READY = 3'b001,
      ST_GOOD = 3'b010,
      ST_WARN = 3'b011,
      ST_STOP = 3'b100
   } pgw_state_e;
endpackage : pgw_pkg

// [core/pgw_tick.sv]
// Clearable divider giving a one-cycle enable pulse every DIV clocks.
`timescale 1ns/1ps
`default_nettype none
module pgw_tick #(
   parameter int DIV = 200000
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control and pulse
   input wire logic clr,
   output logic tick
);
   localparam int W = $clog2(DIV);
   logic [W-1:0] cnt;

   initial begin
      if (DIV < 2) begin
         $error("pgw_tick: DIV must be at least 2");
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (clr) begin
         cnt <= '0;
         tick <= 1'b0;
      end else if (cnt == W'(DIV - 1)) begin
         cnt <= '0;
         tick <= 1'b1;
      end else begin
         cnt <= cnt + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule : pgw_tick
`default_nettype wire

// [core/pgw_timer.sv]
// Millisecond qualification timer: done once run has held for limit ticks.
`timescale 1ns/1ps
`default_nettype none
module pgw_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Control
   input wire logic run,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic done
);
   logic [W-1:0] cnt;

   initial begin
      if (W < 2) begin
         $error("pgw_timer: W must be at least 2");
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
         done <= 1'b0;
      end else if (!run) begin
         cnt <= '0;
         done <= 1'b0;
      end else begin
         done <= (cnt >= limit);
         if (tick && cnt < limit) begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule : pgw_timer
`default_nettype wire
